// ==== verilog/stop_wakeup_config_control.sv ====
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// R1 - Latch each periodic wakeup request; read it as port A bit 6.
// R2 - Port A bit 6 is read-only; no direction, pull-up or data storage.
// R3 - Writing the keyboard acknowledge bit clears the latched wakeup flag.
// R4 - Any reset clears the latched wakeup flag.
// R5 - Wakeup interrupt enable never gates reading of the flag.
// R6 - Wakeup oscillator and counters idle in run mode, active only in stop.
// R7 - Periodic wakeup unit stays idle in wait mode. Here only the counter idles; wakeup_osc_en stays set in stop.
// R8 - With wakeup enable set, the unit starts on every stop entry.
// R9 - Keyboard and wakeup requests leave stop only while unmasked.
// R10 - Wakeup counters restart from zero on every stop entry.
// R11 - Power-disable bit 1 powers monitor down, 0 keeps it powered.
// R12 - Voltage-mode bit 1 selects 5-V trip, 0 selects 3-V trip.
// R13 - Only power-on reset clears the voltage-mode bit.
// R14 - Stop recovery holds core 32 cycles if short bit set, else 4096.
// R15 - Low-voltage reset exit from stop always uses the long delay.
// R16 - After power-on reset, hold core for 4096 cycles.
// R17 - Stop enable 1 enters stop; 0 makes stop an illegal opcode.
// R18 - An illegal opcode generates a reset.
// R19 - Watchdog disable 1 stops the watchdog, 0 lets it run.
// R20 - Recovery count starts on exit acceptance; core held until elapsed.
module stop_wakeup_config_control #(
    parameter int SHORT_REC = stop_pkg::SHORT_REC_CYC,
    parameter int LONG_REC = stop_pkg::LONG_REC_CYC,
    parameter int POR_STAB = stop_pkg::POR_STAB_CYC,
    parameter int WAKE_PERIOD = stop_pkg::WAKE_PERIOD_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core and keyboard side
    input wire logic stop_insn,
    input wire logic wait_mode,
    input wire logic keyboard_ack_bit,
    input wire logic wakeup_interrupt_enable,
    input wire logic keyboard_interrupt_mask,
    input wire logic kbd_req,
    input wire logic lvi_reset_req,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_read_data,
    output logic wakeup_latched_flag,
    output logic wakeup_irq,
    output logic cpu_hold,
    output logic stop_mode,
    output logic wakeup_osc_en,
    output logic illegal_reset,
    output logic supply_monitor_power_disable,
    output logic supply_monitor_voltage_mode,
    output logic watchdog_disable
);
    localparam int RW = $clog2(((LONG_REC > POR_STAB) ? LONG_REC : POR_STAB) + 1);
    localparam logic [RW-1:0] SHORT_LIM = RW'(SHORT_REC);
    localparam logic [RW-1:0] LONG_LIM = RW'(LONG_REC);
    localparam logic [RW-1:0] POR_LIM = RW'(POR_STAB);

    if (SHORT_REC < 2 || SHORT_REC > LONG_REC || POR_STAB < 2) begin : g_bad_counts
        $error("recovery counts out of range");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [7:0] config_image(input stop_pkg::cfg_t c, input logic vm);
        logic [7:0] v;
        v = 8'h00;
        v[stop_pkg::BIT_WDOG_DIS] = c.watchdog_disable;
        v[stop_pkg::BIT_STOP_EN] = c.stop_enable;
        v[stop_pkg::BIT_SHORT_REC] = c.short_recovery_select;
        v[stop_pkg::BIT_VMODE] = vm;
        v[stop_pkg::BIT_PWR_DIS] = c.power_disable;
        return v;
    endfunction : config_image

    function automatic logic word_hit(input logic [31:0] a, input logic [31:0] off);
        return {a[31:2], 2'b00} == off;
    endfunction : word_hit

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    stop_pkg::phase_t phase;
    stop_pkg::phase_t next_phase;
    stop_pkg::cfg_t cfg;
    logic vmode;
    logic enter_stop;
    logic exit_stop;
    logic lvi_exit;
    logic illegal;
    logic [RW-1:0] rec_limit;
    logic [RW-1:0] rec_count;
    logic rec_done;
    logic rec_clear;
    logic wake_run;
    logic wake_tick;
    logic [$clog2(WAKE_PERIOD+1)-1:0] wake_count;
    logic aw_full;
    logic w_full;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic cfg_we;
    logic [7:0] wr_byte;
    logic [RW-1:0] hold_len;

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    always_comb begin
        next_phase = phase;
        enter_stop = 1'b0;
        exit_stop = 1'b0;
        lvi_exit = 1'b0;
        illegal = 1'b0;
        case (phase)
            stop_pkg::PH_POR: begin
                if (rec_done) begin
                    next_phase = stop_pkg::PH_RUN; // [R16]
                end
            end
            stop_pkg::PH_RUN: begin
                if (stop_insn) begin
                    if (cfg.stop_enable) begin
                        next_phase = stop_pkg::PH_STOP; // [R17]
                        enter_stop = 1'b1;
                    end else begin
                        illegal = 1'b1; // [R17] [R18]
                    end
                end
            end
            stop_pkg::PH_STOP: begin
                if (lvi_reset_req) begin
                    next_phase = stop_pkg::PH_RECOVER;
                    exit_stop = 1'b1;
                    lvi_exit = 1'b1;
                end else if ((kbd_req || wake_tick) && !keyboard_interrupt_mask) begin
                    next_phase = stop_pkg::PH_RECOVER; // [R9]
                    exit_stop = 1'b1;
                end
            end
            stop_pkg::PH_RECOVER: begin
                if (rec_done) begin
                    next_phase = stop_pkg::PH_RUN; // [R20]
                end
            end
            default: begin
                next_phase = stop_pkg::PH_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst) begin
            phase <= stop_pkg::PH_POR;
        end else if (sys_rst) begin
            phase <= stop_pkg::PH_RUN;
        end else if (clk_en) begin
            phase <= next_phase;
        end
    end

    // Low-voltage exit ignores the short setting: monitor may not be up yet
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            rec_limit <= POR_LIM; // [R16]
        end else if (clk_en && exit_stop) begin
            if (lvi_exit || !cfg.short_recovery_select) begin
                rec_limit <= LONG_LIM; // [R14] [R15]
            end else begin
                rec_limit <= SHORT_LIM; // [R14]
            end
        end
    end

    assign rec_clear = exit_stop;

    recovery_counter #(
        .W(RW)
    ) u_recovery (
        .ref_clk(ref_clk),
        .por_rst(por_rst),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clear(rec_clear),
        .run(phase == stop_pkg::PH_POR || phase == stop_pkg::PH_RECOVER), // [R20]
        .limit(rec_limit),
        .count(rec_count),
        .done(rec_done)
    );

    // ----------------------------------------
    // Periodic wakeup
    // ----------------------------------------
    assign wake_run = (phase == stop_pkg::PH_STOP) && wakeup_interrupt_enable && !wait_mode; // [R6] [R7] [R8]

    wakeup_timer #(
        .PERIOD(WAKE_PERIOD)
    ) u_wakeup (
        .ref_clk(ref_clk),
        .por_rst(por_rst),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clear(enter_stop),
        .run(wake_run),
        .count(wake_count),
        .tick(wake_tick)
    );

    // Generated resets clear; otherwise a new request beats the acknowledge
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            wakeup_latched_flag <= 1'b0; // [R4]
        end else if (clk_en) begin
            if (illegal || lvi_reset_req) begin
                wakeup_latched_flag <= 1'b0; // [R4]
            end else if (wake_tick) begin
                wakeup_latched_flag <= 1'b1; // [R1]
            end else if (keyboard_ack_bit) begin
                wakeup_latched_flag <= 1'b0; // [R3]
            end
        end
    end

    // Bit 6 has no storage of its own; it is the flag, ungated by enable
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            port_a_read_data <= 8'h00;
        end else if (clk_en) begin
            port_a_read_data <= port_a_in;
            port_a_read_data[stop_pkg::PORTA_FLAG_BIT] <= wakeup_latched_flag; // [R1] [R2] [R5]
        end
    end

    // ----------------------------------------
    // Core-facing status
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst) begin
            cpu_hold <= 1'b1; // [R16]
            stop_mode <= 1'b0;
            wakeup_osc_en <= 1'b0;
            illegal_reset <= 1'b0;
            wakeup_irq <= 1'b0;
        end else if (sys_rst) begin
            cpu_hold <= 1'b0;
            stop_mode <= 1'b0;
            wakeup_osc_en <= 1'b0;
            illegal_reset <= 1'b0;
            wakeup_irq <= 1'b0;
        end else if (clk_en) begin
            cpu_hold <= next_phase != stop_pkg::PH_RUN; // [R20]
            stop_mode <= next_phase == stop_pkg::PH_STOP;
            wakeup_osc_en <= next_phase == stop_pkg::PH_STOP && wakeup_interrupt_enable; // [R6] [R8]
            illegal_reset <= illegal; // [R18]
            wakeup_irq <= wake_tick;
        end
    end

    // ----------------------------------------
    // Configuration bits
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            cfg <= stop_pkg::cfg_t'({stop_pkg::CONFIG_RESET[stop_pkg::BIT_PWR_DIS],
                stop_pkg::CONFIG_RESET[stop_pkg::BIT_SHORT_REC],
                stop_pkg::CONFIG_RESET[stop_pkg::BIT_STOP_EN],
                stop_pkg::CONFIG_RESET[stop_pkg::BIT_WDOG_DIS]});
        end else if (clk_en && cfg_we) begin
            cfg.power_disable <= wr_byte[stop_pkg::BIT_PWR_DIS]; // [R11]
            cfg.short_recovery_select <= wr_byte[stop_pkg::BIT_SHORT_REC];
            cfg.stop_enable <= wr_byte[stop_pkg::BIT_STOP_EN];
            cfg.watchdog_disable <= wr_byte[stop_pkg::BIT_WDOG_DIS]; // [R19]
        end
    end

    // Survives every reset but power-on
    always_ff @(posedge ref_clk or posedge por_rst) begin
        if (por_rst) begin
            vmode <= stop_pkg::CONFIG_RESET[stop_pkg::BIT_VMODE]; // [R13]
        end else if (clk_en && cfg_we) begin
            vmode <= wr_byte[stop_pkg::BIT_VMODE]; // [R12]
        end
    end

    assign supply_monitor_power_disable = cfg.power_disable; // [R11]
    assign supply_monitor_voltage_mode = vmode; // [R12]
    assign watchdog_disable = cfg.watchdog_disable; // [R19]

    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    assign wr_byte = w_data[7:0];
    assign cfg_we = aw_full && w_full && !s_axi_bvalid && w_strb[0]
        && word_hit(aw_addr, stop_pkg::OFF_CONFIG);

    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= stop_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_full && w_full && !s_axi_bvalid) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (word_hit(aw_addr, stop_pkg::OFF_CONFIG)
                        || word_hit(aw_addr, stop_pkg::OFF_STATUS)) begin
                    s_axi_bresp <= stop_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= stop_pkg::RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= stop_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= stop_pkg::RESP_OKAY;
                if (word_hit(s_axi_araddr, stop_pkg::OFF_CONFIG)) begin
                    s_axi_rdata[7:0] <= config_image(cfg, vmode);
                end else if (word_hit(s_axi_araddr, stop_pkg::OFF_STATUS)) begin
                    s_axi_rdata[stop_pkg::STAT_FLAG] <= wakeup_latched_flag; // [R5]
                    s_axi_rdata[stop_pkg::STAT_STOP] <= stop_mode;
                    s_axi_rdata[stop_pkg::STAT_HOLD] <= cpu_hold;
                end else begin
                    s_axi_rresp <= stop_pkg::RESP_DECERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Independent length of the hold, for the recovery checks
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            hold_len <= '0;
        end else if (clk_en) begin
            if (exit_stop) begin
                hold_len <= '0;
            end else if (phase == stop_pkg::PH_RECOVER || phase == stop_pkg::PH_POR) begin
                hold_len <= hold_len + 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (por_rst || sys_rst);

    a_flag_set: assert property (clk_en && wake_tick && !illegal && !lvi_reset_req // [R1]
        |=> wakeup_latched_flag) else $error("wakeup tick not latched");
    a_flag_ack: assert property (clk_en && keyboard_ack_bit && !wake_tick // [R3]
        |=> !wakeup_latched_flag) else $error("acknowledge did not clear flag");
    a_porta_bit: assert property (clk_en ##1 1'b1 // [R5]
        |-> port_a_read_data[stop_pkg::PORTA_FLAG_BIT] == $past(wakeup_latched_flag))
        else $error("port A bit 6 differs from flag");
    a_osc_idle: assert property (phase != stop_pkg::PH_STOP && !enter_stop // [R6]
        |=> $stable(wake_count)) else $error("wakeup unit active outside stop");
    a_stop_zero: assert property (clk_en && enter_stop |=> wake_count == '0) // [R10]
        else $error("wakeup count not restarted");
    a_illegal_stop: assert property (clk_en && phase == stop_pkg::PH_RUN && stop_insn // [R18]
        && !cfg.stop_enable |=> illegal_reset && phase == stop_pkg::PH_RUN)
        else $error("disabled stop not treated as illegal");
    a_mask_hold: assert property (clk_en && phase == stop_pkg::PH_STOP // [R9]
        && keyboard_interrupt_mask && !lvi_reset_req |=> phase == stop_pkg::PH_STOP)
        else $error("masked request left stop");
    a_lvi_long: assert property (clk_en && phase == stop_pkg::PH_STOP && lvi_reset_req // [R15]
        |=> rec_limit == LONG_LIM) else $error("low-voltage exit used short delay");
    a_rec_len: assert property (clk_en && phase == stop_pkg::PH_RECOVER // [R14]
        && next_phase == stop_pkg::PH_RUN |-> hold_len == rec_limit - 1'b1
        && (rec_limit == SHORT_LIM || rec_limit == LONG_LIM))
        else $error("recovery length wrong");
    a_hold_rec: assert property (phase != stop_pkg::PH_RUN |-> cpu_hold) // [R20]
        else $error("core released early");
endmodule : stop_wakeup_config_control

// ==== common/stop_pkg.sv ====
package stop_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] OFF_CONFIG = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int BIT_WDOG_DIS = 0;
    localparam int BIT_STOP_EN = 1;
    localparam int BIT_SHORT_REC = 2;
    localparam int BIT_VMODE = 4;
    localparam int BIT_PWR_DIS = 5;
    localparam int STAT_FLAG = 0;
    localparam int STAT_STOP = 1;
    localparam int STAT_HOLD = 2;
    localparam int PORTA_FLAG_BIT = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ----------------------------------------
    // Timing, in quad bus clock cycles
    // ----------------------------------------
    localparam int SHORT_REC_CYC = 32;
    localparam int LONG_REC_CYC = 4096;
    localparam int POR_STAB_CYC = 4096;
    localparam int WAKE_PERIOD_CYC = 512;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        PH_POR = 2'b00,
        PH_RUN = 2'b01,
        PH_STOP = 2'b10,
        PH_RECOVER = 2'b11
    } phase_t;

    typedef struct packed {
        logic power_disable;
        logic short_recovery_select;
        logic stop_enable;
        logic watchdog_disable;
    } cfg_t;
endpackage : stop_pkg

// ==== verilog/recovery_counter.sv ====
`timescale 1ns/1ns
module recovery_counter #(
    parameter int W = 13
) (
    input wire logic ref_clk,
    input wire logic por_rst,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic [W-1:0] count,
    output logic done
);
    if (W < 2) begin : g_bad_w
        $error("recovery_counter width too small");
    end

    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            count <= '0;
        end else if (clk_en) begin
            if (clear) begin
                count <= '0;
            end else if (run) begin
                count <= count + 1'b1;
            end
        end
    end

    assign done = run && !clear && (count == limit - 1'b1);
endmodule : recovery_counter

// ==== verilog/wakeup_timer.sv ====
`timescale 1ns/1ns
module wakeup_timer #(
    parameter int PERIOD = stop_pkg::WAKE_PERIOD_CYC
) (
    input wire logic ref_clk,
    input wire logic por_rst,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic run,
    output logic [$clog2(PERIOD+1)-1:0] count,
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    if (PERIOD < 2) begin : g_bad_period
        $error("wakeup_timer period too small");
    end

    // Restarts from zero on every stop entry, never resumes
    always_ff @(posedge ref_clk or posedge por_rst or posedge sys_rst) begin
        if (por_rst || sys_rst) begin
            count <= '0;
        end else if (clk_en) begin
            if (clear || (run && count == LAST)) begin
                count <= '0; // [R10]
            end else if (run) begin
                count <= count + 1'b1;
            end
        end
    end

    assign tick = run && !clear && (count == LAST);
endmodule : wakeup_timer

// ==== tb/core_kbd_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Core and keyboard side model
// ----------------------------------------
module core_kbd_model (
    input wire logic ref_clk,
    output logic stop_insn,
    output logic keyboard_ack_bit,
    output logic kbd_req,
    output logic low_volt_req,
    output logic [7:0] port_a_in
);
    initial begin
        stop_insn = 1'b0;
        keyboard_ack_bit = 1'b0;
        kbd_req = 1'b0;
        low_volt_req = 1'b0;
        port_a_in = 8'ha5;
    end
    // One-cycle event: 0 stop, 1 ack, 2 keyboard request, 3 low-voltage reset
    task pulse(input int which);
        @(posedge ref_clk);
        stop_insn <= (which == 0);
        keyboard_ack_bit <= (which == 1);
        kbd_req <= (which == 2);
        low_volt_req <= (which == 3);
        @(posedge ref_clk);
        {stop_insn, keyboard_ack_bit, kbd_req, low_volt_req} <= 4'h0;
    endtask : pulse
endmodule : core_kbd_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 0, sys_rst = 1, por_rst = 1, wie = 0, mask = 1, ce = 1, wm = 0;
    logic [3:0] strb = 4'hf;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, stop_insn, ack, kreq, lvr;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] pa_in, pa;
    logic flag, hold, stp, osc, illr, pwr, vm, wd, irq;
    int err_total = 0, comparisons = 0, n;
    always #5 ref_clk = ~ref_clk;
    core_kbd_model p (.ref_clk(ref_clk), .stop_insn(stop_insn), .keyboard_ack_bit(ack),
        .kbd_req(kreq), .low_volt_req(lvr), .port_a_in(pa_in));
    // Short counts keep the run brief
    stop_wakeup_config_control #(.SHORT_REC(4), .LONG_REC(16), .POR_STAB(16),
        .WAKE_PERIOD(8)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
        .clk_en(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .stop_insn(stop_insn), .wait_mode(wm), .keyboard_ack_bit(ack),
        .wakeup_interrupt_enable(wie), .keyboard_interrupt_mask(mask), .kbd_req(kreq),
        .lvi_reset_req(lvr), .port_a_in(pa_in), .port_a_read_data(pa),
        .wakeup_latched_flag(flag), .wakeup_irq(irq), .cpu_hold(hold), .stop_mode(stp),
        .wakeup_osc_en(osc), .illegal_reset(illr), .supply_monitor_power_disable(pwr),
        .supply_monitor_voltage_mode(vm), .watchdog_disable(wd));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task print_verdict;
        $display("Counts: %0d compared, %0d bad", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task limit(input int k);
        if (k >= 50) begin
            err_total++;
            print_verdict;
        end
    endtask : limit
    task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        {awaddr, wdata, strb, awvalid, wvalid, bready} <= {a, d, s, 3'h7};
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awready && awvalid) awvalid <= 0;
            if (wready && wvalid) wvalid <= 0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 0;
        limit(n);
    endtask : axi_wr
    task axi_rd(input logic [31:0] a);
        @(posedge ref_clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arready && arvalid) arvalid <= 0;
            if (rvalid) break;
        end
        {rd, resp} = {rdata, rresp};
        rready <= 0;
        limit(n);
    endtask : axi_rd
    // Edges until the core is released, counted from the edge the task is entered on
    task hold_len(input int exp);
        #1;
        for (n = 0; n < 60 && hold !== 0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("hold_len", n, exp);
    endtask : hold_len
    initial begin
        repeat (10) @(posedge ref_clk);
        {por_rst, sys_rst} <= 2'h0;
        hold_len(16);
        axi_rd(stop_pkg::OFF_CONFIG);
        chk("cfg_reset", rd, 0);
        axi_wr(stop_pkg::OFF_CONFIG, 32'h37, 4'hf);
        chk("wr_resp", resp, stop_pkg::RESP_OKAY);
        #1 chk("cfg_out", {pwr, vm, wd}, 3'h7);
        axi_rd(32'h40);
        chk("unmapped", resp, stop_pkg::RESP_DECERR);
        @(posedge ref_clk) sys_rst <= 1;
        @(posedge ref_clk) sys_rst <= 0;
        #1 chk("vmode_kept", {pwr, vm, wd}, 3'h2);
        // Low strobe byte off: the write must leave every bit alone
        axi_wr(stop_pkg::OFF_CONFIG, 32'h21, 4'he);
        #1 chk("strb_off", {pwr, vm, wd}, 3'h2);
        $display("Config test done");
        p.pulse(0);
        #1 chk("illegal", {illr, stp}, 2'h2);
        axi_wr(stop_pkg::OFF_CONFIG, 32'h06, 4'hf);
        wie <= 1;
        p.pulse(0);
        #1 chk("stop", {stp, hold, osc}, 3'h7);
        repeat (12) @(posedge ref_clk);
        wie <= 0;
        #1 chk("masked", {stp, flag}, 2'h3);
        @(posedge ref_clk);
        mask <= 0;
        #1 chk("port_a", pa, 8'he5);
        axi_rd(stop_pkg::OFF_STATUS);
        chk("status", rd, 32'h7);
        p.pulse(2);
        // Frozen edges must not count toward the hold
        ce <= 0;
        repeat (3) @(posedge ref_clk);
        ce <= 1;
        hold_len(4);
        chk("run_osc", {flag, osc}, 2'h2);
        p.pulse(1);
        {wie, mask} <= 2'h3;
        #2 chk("ack", flag, 0);
        $display("Short stop test done");
        // Counter was left at 4; resuming would expire within 4 edges
        p.pulse(0);
        repeat (6) @(posedge ref_clk);
        #1 chk("restart", flag, 0);
        p.pulse(3);
        hold_len(16);
        p.pulse(0);
        wm <= 1;
        repeat (4) @(posedge ref_clk);
        wm <= 0;
        repeat (5) @(posedge ref_clk);
        #1 chk("wait_idle", flag, 0);
        repeat (3) @(posedge ref_clk);
        #1 chk("wake", {flag, irq}, 2'h3);
        p.pulse(3);
        #2 chk("reset_clr", flag, 0);
        $display("Long stop test done");
        print_verdict;
    end
endmodule : testbench
